// ---- hw/elf_pkg.sv ----
`default_nettype none

package elf_pkg;

    // ==========================================================
    // widths
    localparam int REG_AW = 6;
    localparam int REG_DW = 24;
    localparam int ADC_W = 14;
    localparam int ACC_W = 24;
    localparam int CALC_W = 27;
    localparam int CH_N = 5;
    localparam int CM_SEL_W = 8;
    localparam int CNT_W = 10;

    // ==========================================================
    // register offsets, field positions, reset values
    localparam logic [5:0] ADDR_CHAN_CTL = 6'h01;
    localparam logic [5:0] ADDR_CMREF_CTL = 6'h05;
    localparam logic [5:0] ADDR_FRAME_CTL = 6'h0A;
    localparam int CHCFG_BIT = 10;
    localparam int CE_EN_BIT = 8;
    localparam int FMT_BIT = 4;
    localparam int RATE_LSB = 0;
    localparam int UNAVAIL_BIT = 23;
    localparam logic [23:0] CHAN_CTL_RST = 24'h000000;
    localparam logic [23:0] CMREF_CTL_RST = 24'h000000;
    localparam logic [23:0] FRAME_CTL_RST = 24'h000000;

    // ==========================================================
    // data rates: code, window length minus one, scale shift
    localparam logic [1:0] RATE_2K = 2'h0;
    localparam logic [1:0] RATE_16K = 2'h1;
    localparam logic [CNT_W-1:0] DEC_LAST_2K = 10'h3FF;
    localparam logic [CNT_W-1:0] DEC_LAST_16K = 10'h07F;
    localparam logic [CNT_W-1:0] DEC_LAST_128K = 10'h00F;
    localparam logic [2:0] SH_2K = 3'h0;
    localparam logic [2:0] SH_16K = 3'h3;
    localparam logic [2:0] SH_128K = 3'h6;

    // ==========================================================
    // converter timing and midscale reference code
    localparam int CLK_HZ = 100_000_000;
    localparam int ADC_RATE_HZ = 2_000_000;
    localparam int ADC_DIV = CLK_HZ / ADC_RATE_HZ;
    localparam logic [5:0] ADC_DIV_LAST = 6'(ADC_DIV - 1);
    localparam logic [14:0] ADC_MID = 15'h2000;

    typedef enum logic [2:0] {
        ELF_MODE_DIG_LEAD,
        ELF_MODE_CE_LEAD,
        ELF_MODE_ANA_LEAD,
        ELF_MODE_ELEC_VCM,
        ELF_MODE_ELEC_CE
    } elf_mode_t;

endpackage

`default_nettype wire

// ---- hw/elf_lead_formation.sv ----
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - format select 0 gives lead words (electrode words at 128 kHz without channel config), 1 gives electrode words.
// - channel config 0 single-ended input, 1 analog lead formation.
// - common electrode enable switches frame words to CE referencing, except in analog lead mode.
// - digital lead mode computes leads I, II, III and V1', V2'.
// - limb average is (RA+LA+LL)/3, subtracted from chest samples.
// - digital leads only at 2 kHz and 16 kHz rates.
// - at 128 kHz only analog lead mode yields lead data.
// - digital lead mode ignores the common-mode switch selection.
// - analog mode lead II arrives inverted and is negated here.
// - channel config alone: leads I-III, then V1, V2 against common mode.
// - format alone: LA, LL, RA, V1, V2 relative to common mode.
// - format plus CE: LA, LL, V1, V2, V3 relative to common electrode.
// - CE alone: leads I, II, then V3', V1', V2' from CE differences.
// - midscale reference offset is removed from all output data.
// - lead or electrode frames are produced at every frame rate.
// - augmented leads are left to the host, never computed here.
// - 14-bit converter at 2 MHz, 1024x, 128x or 16x oversampled per result.
module elf_lead_formation (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [elf_pkg::REG_AW-1:0] reg_addr,
    input wire logic [elf_pkg::REG_DW-1:0] reg_wdata,
    output logic [elf_pkg::REG_DW-1:0] reg_rdata_q,
    input wire logic [elf_pkg::ADC_W-1:0] adc_la,
    input wire logic [elf_pkg::ADC_W-1:0] adc_ll,
    input wire logic [elf_pkg::ADC_W-1:0] adc_ra,
    input wire logic [elf_pkg::ADC_W-1:0] adc_v1,
    input wire logic [elf_pkg::ADC_W-1:0] adc_v2,
    output logic adc_start_q,
    output logic frame_valid_q,
    output logic [elf_pkg::ACC_W-1:0] word1_q,
    output logic [elf_pkg::ACC_W-1:0] word2_q,
    output logic [elf_pkg::ACC_W-1:0] word3_q,
    output logic [elf_pkg::ACC_W-1:0] word4_q,
    output logic [elf_pkg::ACC_W-1:0] word5_q,
    output logic analog_lead_q,
    output logic [elf_pkg::CM_SEL_W-1:0] cm_switch_q,
    output logic lead_unavail_q
);

    localparam int AW = elf_pkg::ACC_W;
    localparam int CW = elf_pkg::CALC_W;

    // ==========================================================
    // helpers
    function automatic logic [AW-1:0] sat(input logic signed [CW-1:0] v);
        logic signed [CW-1:0] hi;
        logic signed [CW-1:0] lo;
        hi = CW'(signed'({1'b0, {(AW-1){1'b1}}}));
        lo = -hi - CW'(1);
        if (v > hi) begin
            sat = {1'b0, {(AW-1){1'b1}}};
        end else if (v < lo) begin
            sat = {1'b1, {(AW-1){1'b0}}};
        end else begin
            sat = v[AW-1:0];
        end
    endfunction

    function automatic elf_pkg::elf_mode_t decode(input logic fmt, input logic chcfg,
                                                   input logic ce, input logic fast);
        if (!fmt && chcfg) begin
            decode = elf_pkg::ELF_MODE_ANA_LEAD;
        end else if (!fmt && fast) begin
            // digitally formed leads cannot keep up at the top rate
            decode = ce ? elf_pkg::ELF_MODE_ELEC_CE : elf_pkg::ELF_MODE_ELEC_VCM;
        end else if (!fmt) begin
            decode = ce ? elf_pkg::ELF_MODE_CE_LEAD : elf_pkg::ELF_MODE_DIG_LEAD;
        end else begin
            decode = ce ? elf_pkg::ELF_MODE_ELEC_CE : elf_pkg::ELF_MODE_ELEC_VCM;
        end
    endfunction

    // ==========================================================
    // registers
    logic [23:0] ecg_channel_control_q;
    logic [23:0] common_mode_reference_control_q;
    logic [23:0] frame_format_control_q;
    logic output_format_select;
    logic channel_input_config;
    logic common_electrode_enable;
    logic [1:0] rate_sel;

    assign output_format_select = frame_format_control_q[elf_pkg::FMT_BIT];
    assign channel_input_config = ecg_channel_control_q[elf_pkg::CHCFG_BIT];
    assign common_electrode_enable = common_mode_reference_control_q[elf_pkg::CE_EN_BIT];
    assign rate_sel = frame_format_control_q[elf_pkg::RATE_LSB +: 2];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ecg_channel_control_q <= elf_pkg::CHAN_CTL_RST;
            common_mode_reference_control_q <= elf_pkg::CMREF_CTL_RST;
            frame_format_control_q <= elf_pkg::FRAME_CTL_RST;
        end else if (reg_wr) begin
            case (reg_addr)
                elf_pkg::ADDR_CHAN_CTL: begin
                    ecg_channel_control_q <= reg_wdata;
                end
                elf_pkg::ADDR_CMREF_CTL: begin
                    common_mode_reference_control_q <= reg_wdata;
                end
                elf_pkg::ADDR_FRAME_CTL: begin
                    frame_format_control_q <= reg_wdata;
                    frame_format_control_q[elf_pkg::UNAVAIL_BIT] <= 1'b0;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q <= 24'h000000;
        end else if (reg_rd) begin
            case (reg_addr)
                elf_pkg::ADDR_CHAN_CTL: begin
                    reg_rdata_q <= ecg_channel_control_q;
                end
                elf_pkg::ADDR_CMREF_CTL: begin
                    reg_rdata_q <= common_mode_reference_control_q;
                end
                elf_pkg::ADDR_FRAME_CTL: begin
                    reg_rdata_q <= {lead_unavail_q, frame_format_control_q[22:0]};
                end
                default: begin
                    reg_rdata_q <= 24'h000000;
                end
            endcase
        end
    end

    // ==========================================================
    // analog switch steering
    // input stage select
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            analog_lead_q <= 1'b0;
            cm_switch_q <= '0;
        end else begin
            analog_lead_q <= channel_input_config;
            if (!output_format_select && !channel_input_config && !common_electrode_enable) begin
                cm_switch_q <= '0;
            end else begin
                cm_switch_q <= common_mode_reference_control_q[elf_pkg::CM_SEL_W-1:0];
            end
        end
    end

    // ==========================================================
    // converter strobe and oversampling
    logic [5:0] div_cnt_q;
    logic adc_en;
    logic [elf_pkg::CNT_W-1:0] smp_cnt_q;
    logic [elf_pkg::CNT_W-1:0] dec_last;
    logic [2:0] dec_sh;
    logic [1:0] rate_q;
    logic [1:0] frm_rate_q;
    logic win_end;
    logic sum_vld_q;
    elf_pkg::elf_mode_t mode_q;
    logic [elf_pkg::ADC_W-1:0] adc_in [elf_pkg::CH_N];
    logic signed [AW-1:0] sum_q [elf_pkg::CH_N];

    assign adc_in[0] = adc_la;
    assign adc_in[1] = adc_ll;
    assign adc_in[2] = adc_ra;
    assign adc_in[3] = adc_v1;
    assign adc_in[4] = adc_v2;
    assign adc_en = (div_cnt_q == elf_pkg::ADC_DIV_LAST);

    always_comb begin
        case (rate_q)
            elf_pkg::RATE_2K: begin
                dec_last = elf_pkg::DEC_LAST_2K;
                dec_sh = elf_pkg::SH_2K;
            end
            elf_pkg::RATE_16K: begin
                dec_last = elf_pkg::DEC_LAST_16K;
                dec_sh = elf_pkg::SH_16K;
            end
            default: begin
                dec_last = elf_pkg::DEC_LAST_128K;
                dec_sh = elf_pkg::SH_128K;
            end
        endcase
    end

    assign win_end = adc_en && (smp_cnt_q == dec_last);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt_q <= '0;
            adc_start_q <= 1'b0;
        end else begin
            div_cnt_q <= adc_en ? 6'h00 : div_cnt_q + 6'h01;
            adc_start_q <= adc_en;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            smp_cnt_q <= '0;
            rate_q <= elf_pkg::RATE_2K;
            frm_rate_q <= elf_pkg::RATE_2K;
            mode_q <= elf_pkg::ELF_MODE_DIG_LEAD;
            sum_vld_q <= 1'b0;
        end else begin
            sum_vld_q <= win_end;
            if (adc_en) begin
                smp_cnt_q <= win_end ? '0 : smp_cnt_q + 10'h001;
            end
            if (win_end) begin
                mode_q <= decode(output_format_select, channel_input_config,
                                 common_electrode_enable, rate_q[1]);
                frm_rate_q <= rate_q;
                rate_q <= rate_sel;
            end
        end
    end

    // the window keeps the full-scale meaning equal at every rate
    for (genvar i = 0; i < elf_pkg::CH_N; i++) begin : g_ch
        logic signed [AW-1:0] acc_q;
        logic signed [AW-1:0] acc_nx;
        logic signed [14:0] smp;
        assign smp = signed'({1'b0, adc_in[i]} - elf_pkg::ADC_MID);
        assign acc_nx = acc_q + {{(AW-15){smp[14]}}, smp};
        always_ff @(posedge clk_sys or negedge rst_n) begin
            if (!rst_n) begin
                acc_q <= '0;
                sum_q[i] <= '0;
            end else if (adc_en) begin
                acc_q <= win_end ? '0 : acc_nx;
                if (win_end) begin
                    sum_q[i] <= acc_nx <<< dec_sh;
                end
            end
        end
    end

    // ==========================================================
    // lead and electrode formation
    logic signed [CW-1:0] s0, s1, s2, s3, s4;
    logic signed [CW-1:0] avg3;
    logic signed [CW-1:0] ce3;

    assign s0 = CW'(sum_q[0]);
    assign s1 = CW'(sum_q[1]);
    assign s2 = CW'(sum_q[2]);
    assign s3 = CW'(sum_q[3]);
    assign s4 = CW'(sum_q[4]);
    assign avg3 = (s0 + s1 + s2) / 27'sd3;
    assign ce3 = (s0 + s1) / 27'sd3;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            frame_valid_q <= 1'b0;
            lead_unavail_q <= 1'b0;
            word1_q <= '0;
            word2_q <= '0;
            word3_q <= '0;
            word4_q <= '0;
            word5_q <= '0;
        end else begin
            frame_valid_q <= sum_vld_q;
            if (sum_vld_q) begin
                lead_unavail_q <= frm_rate_q[1] && !output_format_select
                                  && !channel_input_config;
                case (mode_q)
                    elf_pkg::ELF_MODE_DIG_LEAD: begin
                        word1_q <= sat(s0 - s2);
                        word2_q <= sat(s1 - s2);
                        word3_q <= sat(s1 - s0);
                        word4_q <= sat(s3 - avg3);
                        word5_q <= sat(s4 - avg3);
                    end
                    elf_pkg::ELF_MODE_CE_LEAD: begin
                        word1_q <= sat(s0);
                        word2_q <= sat(s1);
                        word3_q <= sat(s2 - ce3);
                        word4_q <= sat(s3 - ce3);
                        word5_q <= sat(s4 - ce3);
                    end
                    elf_pkg::ELF_MODE_ANA_LEAD: begin
                        word1_q <= sat(s0);
                        word2_q <= sat(-s1);
                        word3_q <= sat(s2);
                        word4_q <= sat(s3);
                        word5_q <= sat(s4);
                    end
                    elf_pkg::ELF_MODE_ELEC_CE: begin
                        word1_q <= sat(s0);
                        word2_q <= sat(s1);
                        word3_q <= sat(s3);
                        word4_q <= sat(s4);
                        word5_q <= sat(s2);
                    end
                    default: begin
                        word1_q <= sat(s0);
                        word2_q <= sat(s1);
                        word3_q <= sat(s2);
                        word4_q <= sat(s3);
                        word5_q <= sat(s4);
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // assertions
    a_dig_lead_i: assert property (@(posedge clk_sys) disable iff (!rst_n)
        frame_valid_q && mode_q == elf_pkg::ELF_MODE_DIG_LEAD |-> word1_q == sat(s0 - s2)
        && word3_q == sat(s1 - s0)) else $error("digital lead I or III wrong");
    a_limb_avg: assert property (@(posedge clk_sys) disable iff (!rst_n)
        frame_valid_q && mode_q == elf_pkg::ELF_MODE_DIG_LEAD
        |-> word4_q == sat(s3 - (s0 + s1 + s2) / 27'sd3)) else $error("limb average wrong");
    a_ana_negate: assert property (@(posedge clk_sys) disable iff (!rst_n)
        frame_valid_q && mode_q == elf_pkg::ELF_MODE_ANA_LEAD |-> word2_q == sat(-s1)
        && word4_q == sat(s3)) else $error("analog lead II polarity wrong");
    a_ce_lead: assert property (@(posedge clk_sys) disable iff (!rst_n)
        frame_valid_q && mode_q == elf_pkg::ELF_MODE_CE_LEAD
        |-> word3_q == sat(s2 - (s0 + s1) / 27'sd3)) else $error("CE chest lead wrong");
    a_elec_ce: assert property (@(posedge clk_sys) disable iff (!rst_n)
        frame_valid_q && mode_q == elf_pkg::ELF_MODE_ELEC_CE |-> word3_q == sat(s3)
        && word5_q == sat(s2)) else $error("CE electrode order wrong");
    a_no_fast_dig: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sum_vld_q && frm_rate_q[1] |-> mode_q != elf_pkg::ELF_MODE_DIG_LEAD
        && mode_q != elf_pkg::ELF_MODE_CE_LEAD) else $error("digital leads at 128k");
    a_cm_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !output_format_select && !channel_input_config && !common_electrode_enable
        |=> cm_switch_q == '0) else $error("cm selection not ignored");
    a_mode_boundary: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $changed(mode_q) |-> sum_vld_q) else $error("mode changed inside a frame");
    a_adc_period: assert property (@(posedge clk_sys) disable iff (!rst_n)
        adc_start_q |-> ##50 adc_start_q) else $error("converter strobe period wrong");
    a_frame_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
        frame_valid_q |=> !frame_valid_q [*8]) else $error("frame strobe not a pulse");

endmodule

`default_nettype wire

// ---- test/elf_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// host side frame reader
// single device, no ganged slave to configure
module elf_host_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic frame_valid_q,
    input wire logic [elf_pkg::ACC_W-1:0] word1_q,
    input wire logic [elf_pkg::ACC_W-1:0] word2_q,
    input wire logic [elf_pkg::ACC_W-1:0] word3_q,
    input wire logic [elf_pkg::ACC_W-1:0] word4_q,
    input wire logic [elf_pkg::ACC_W-1:0] word5_q,
    input wire logic lead_unavail_q,
    output logic seen_q,
    output logic [elf_pkg::ACC_W-1:0] w1_q,
    output logic [elf_pkg::ACC_W-1:0] w2_q,
    output logic [elf_pkg::ACC_W-1:0] w3_q,
    output logic [elf_pkg::ACC_W-1:0] w4_q,
    output logic [elf_pkg::ACC_W-1:0] w5_q,
    output logic unavail_q
);
    // raw words only, augmented leads left for later software
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            seen_q <= 1'b0;
        end else begin
            seen_q <= frame_valid_q;
        end
    end

    // words are only grabbed in the pulse cycle; no trust in later hold
    always_ff @(posedge clk_sys) begin
        if (frame_valid_q) begin
            w1_q <= word1_q;
            w2_q <= word2_q;
            w3_q <= word3_q;
            w4_q <= word4_q;
            w5_q <= word5_q;
            unavail_q <= lead_unavail_q;
        end
    end
endmodule

`default_nettype wire

// ---- test/elf_lead_formation_test.sv ----
`timescale 1ns/1ps
`default_nettype none

module elf_lead_formation_test;
    typedef struct packed {
        logic [4:0][23:0] w;
        logic unav;
        logic alq;
        logic [7:0] cm;
        logic [10:0] n;
    } elf_exp_t;

    logic clk_sys, rst_n, reg_wr, reg_rd, rd_pend, frame_valid_q, analog_lead_q;
    logic lead_unavail_q, seen_q, h_unav, adc_start_q;
    logic [5:0] reg_addr;
    logic [23:0] reg_wdata, reg_rdata_q;
    logic [13:0] adc [5];
    logic [23:0] word [5];
    logic [23:0] h_w [5];
    logic [7:0] cm_switch_q;
    int mismatches, check_count, cycles, strobes;
    elf_exp_t fq [$];
    elf_exp_t cur;
    logic [23:0] rq [$];

    elf_lead_formation elf_lead_formation_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata_q(reg_rdata_q), .adc_la(adc[0]), .adc_ll(adc[1]), .adc_ra(adc[2]),
        .adc_v1(adc[3]), .adc_v2(adc[4]), .adc_start_q(adc_start_q),
        .frame_valid_q(frame_valid_q),
        .word1_q(word[0]), .word2_q(word[1]), .word3_q(word[2]), .word4_q(word[3]),
        .word5_q(word[4]), .analog_lead_q(analog_lead_q), .cm_switch_q(cm_switch_q),
        .lead_unavail_q(lead_unavail_q));

    elf_host_model elf_host_model_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .frame_valid_q(frame_valid_q), .word1_q(word[0]), .word2_q(word[1]),
        .word3_q(word[2]), .word4_q(word[3]), .word5_q(word[4]),
        .lead_unavail_q(lead_unavail_q), .seen_q(seen_q), .w1_q(h_w[0]), .w2_q(h_w[1]),
        .w3_q(h_w[2]), .w4_q(h_w[3]), .w5_q(h_w[4]), .unavail_q(h_unav));

    // ==========================================================
    // helpers
    task check(input logic [23:0] seen, input logic [23:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t value %h expected %h", $time, seen, exp);
        end
    endtask

    task report_and_stop;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task reg_write(input logic [5:0] a, input logic [23:0] d);
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
    endtask

    task reg_read(input logic [5:0] a, input logic [23:0] e);
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        rq.push_back(e);
    endtask

    task bus_idle;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
    endtask

    // constant codes over a window give sums of 1024 per unit at every rate
    function automatic elf_exp_t expect_frame(input logic [2:0] sel, input logic [1:0] r,
                                              input int d [5], input logic [7:0] cm);
        int s [5];
        int v [5];
        int a;
        elf_exp_t e;
        // 1024 samples per result, shorter windows scaled up
        for (int i = 0; i < 5; i++) s[i] = d[i] * 1024;
        e.unav = 1'b0;
        if (!sel[2] && sel[1]) begin
            v = '{s[0], -s[1], s[2], s[3], s[4]};
        end else if (!sel[2] && r < 2 && !sel[0]) begin
            a = (s[0] + s[1] + s[2]) / 3;
            v = '{s[0] - s[2], s[1] - s[2], s[1] - s[0], s[3] - a, s[4] - a};
        end else if (!sel[2] && r < 2) begin
            a = (s[0] + s[1]) / 3;
            v = '{s[0], s[1], s[2] - a, s[3] - a, s[4] - a};
        end else begin
            e.unav = !sel[2];
            v = s;
            if (sel[0]) begin
                v = '{s[0], s[1], s[3], s[4], s[2]};
            end
        end
        for (int i = 0; i < 5; i++) e.w[i] = 24'(v[i]);
        e.alq = sel[1];
        e.cm = (sel == 3'h0) ? 8'h00 : cm;
        // strobes per window at the rate that window ran
        e.n = (r == 2'h0) ? 11'h400 : ((r == 2'h1) ? 11'h080 : 11'h010);
        return e;
    endfunction

    // ==========================================================
    // clock, reset, timeout
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 90000) begin
            mismatches++;
            $display("BAD %0t timeout waiting for frames", $time);
            report_and_stop;
        end
    end

    // ==========================================================
    // output watcher
    always @(negedge clk_sys) begin
        if (rd_pend) begin
            check(reg_rdata_q, rq.pop_front());
        end
        rd_pend = reg_rd;
        if (adc_start_q === 1'b1) begin
            strobes++;
        end
        if (seen_q === 1'b1) begin
            if (fq.size() == 0) begin
                mismatches++;
                $display("BAD %0t frame with nothing expected", $time);
            end else begin
                cur = fq.pop_front();
                check(h_w[0], cur.w[0]);
                check(h_w[1], cur.w[1]);
                check(h_w[2], cur.w[2]);
                check(h_w[3], cur.w[3]);
                check(h_w[4], cur.w[4]);
                check(24'(strobes), 24'(cur.n));
                check(24'(h_unav), 24'(cur.unav));
                check(24'(cm_switch_q), 24'(cur.cm));
                check(24'(analog_lead_q), 24'(cur.alq));
            end
            strobes = 0;
        end
    end

    // ==========================================================
    // stimulus: one config step per window, expectation for that window
    initial begin
        logic [2:0] sel_t [10];
        logic [1:0] rate_t [10];
        int d [5];
        logic [1:0] rw;
        logic [7:0] cm;
        logic unav;
        sel_t = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h0, 3'h1, 3'h2, 3'h0, 3'h0};
        rate_t = '{2'h1, 2'h1, 2'h2, 2'h3, 2'h2, 2'h2, 2'h2, 2'h2, 2'h1, 2'h1};
        void'($urandom(39749));
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        rd_pend = 1'b0;
        reg_addr = 6'h00;
        reg_wdata = 24'h000000;
        for (int i = 0; i < 5; i++) adc[i] = 14'h2000;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        // reset values and unmapped space read as zero
        reg_read(elf_pkg::ADDR_FRAME_CTL, elf_pkg::FRAME_CTL_RST);
        reg_read(elf_pkg::ADDR_CHAN_CTL, elf_pkg::CHAN_CTL_RST);
        reg_read(elf_pkg::ADDR_CMREF_CTL, elf_pkg::CMREF_CTL_RST);
        reg_write(6'h02, 24'hFFFFFF);
        reg_read(6'h02, 24'h000000);
        bus_idle;
        rw = 2'h0;
        unav = 1'b0;
        // mode bits written inside a window shape its own frame, the rate field only the next window
        for (int k = 0; k < 10; k++) begin
            for (int i = 0; i < 5; i++) d[i] = int'($urandom_range(4000)) - 2000;
            cm = 8'($urandom_range(255)) | 8'h01;
            @(posedge clk_sys);
            for (int i = 0; i < 5; i++) adc[i] <= 14'(int'(elf_pkg::ADC_MID) + d[i]);
            // bit 23 written high must not stick
            reg_write(elf_pkg::ADDR_FRAME_CTL, {1'b1, 18'h00000, sel_t[k][2], 2'h0, rate_t[k]});
            reg_write(elf_pkg::ADDR_CHAN_CTL, 24'(sel_t[k][1]) << elf_pkg::CHCFG_BIT);
            reg_write(elf_pkg::ADDR_CMREF_CTL, (24'(sel_t[k][0]) << elf_pkg::CE_EN_BIT) | 24'(cm));
            bus_idle;
            reg_read(elf_pkg::ADDR_FRAME_CTL, {unav, 18'h00000, sel_t[k][2], 2'h0, rate_t[k]});
            reg_read(elf_pkg::ADDR_CHAN_CTL, 24'(sel_t[k][1]) << elf_pkg::CHCFG_BIT);
            reg_read(elf_pkg::ADDR_CMREF_CTL, (24'(sel_t[k][0]) << elf_pkg::CE_EN_BIT) | 24'(cm));
            bus_idle;
            fq.push_back(expect_frame(sel_t[k], rw, d, cm));
            rw = rate_t[k];
            unav = fq[$].unav;
            // every window closes with a frame
            @(posedge frame_valid_q);
            @(negedge clk_sys);
        end
        repeat (5) @(posedge clk_sys);
        check(24'(fq.size()), 24'h000000);
        report_and_stop;
    end
endmodule

`default_nettype wire
